// file: cfg_msg_pkg.sv
// Shared constants and a helper function for the configuration message link
package cfg_msg_pkg;

  // ----------------------------------------------------------------
  // Control token codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TOK_WRITE = 8'hC0;  // 192
  localparam logic [7:0] TOK_READ  = 8'hC1;  // 193
  localparam logic [7:0] TOK_END   = 8'h01;
  localparam logic [7:0] TOK_ACK   = 8'h03;
  localparam logic [7:0] TOK_NACK  = 8'h04;

  // ----------------------------------------------------------------
  // Field sizes in bytes, minus one (counter end values)
  // ----------------------------------------------------------------
  localparam logic [2:0] RID_LAST  = 3'h2;
  localparam logic [2:0] REG_LAST  = 3'h1;
  localparam logic [2:0] DATA_LAST = 3'h3;

  // ----------------------------------------------------------------
  // Reply suppression and endpoint addressing
  // ----------------------------------------------------------------
  localparam logic [7:0]  RID_NO_REPLY = 8'hFF;
  localparam logic [15:0] TILE_EP_LO   = 16'hC20C;
  localparam logic [15:0] NODE_EP_LO   = 16'hC30C;

  // ----------------------------------------------------------------
  // Local processor status resource identifier
  // ----------------------------------------------------------------
  localparam int unsigned PS_SHIFT = 8;
  localparam logic [7:0]  PS_CODE  = 8'h0B;

  function automatic logic [31:0] ps_resource_id(input logic [15:0] reg_num);
    ps_resource_id = (32'(reg_num) << PS_SHIFT) | 32'(PS_CODE);
  endfunction : ps_resource_id

endpackage : cfg_msg_pkg

// file: cfg_link_if.sv
// Token link between a requesting channel-end and a configuration agent
`timescale 1ns/1ps
interface cfg_link_if;
  logic        req_valid;
  logic        req_ctrl;
  logic [7:0]  req_data;
  logic [31:0] req_dest;
  logic        req_ready;
  logic        rsp_valid;
  logic        rsp_ctrl;
  logic [7:0]  rsp_data;
  logic [23:0] rsp_dest;
  logic        rsp_ready;

  modport agent (
    input  req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );

  modport requester (
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input  req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface : cfg_link_if

// file: cfg_requester.sv
// Channel-end that sends configuration read and write messages
`timescale 1ns/1ps
module cfg_requester
  import cfg_msg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  cfg_link_if.requester    link,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_node,
  input  wire logic [15:0] cmd_target_id,
  input  wire logic [23:0] cmd_reply_id,
  input  wire logic [15:0] cmd_reg,
  input  wire logic [31:0] cmd_wdata,
  output logic             cmd_ready,
  output logic [31:0]      ps_res_id,
  output logic             done,
  output logic             done_ok,
  output logic [31:0]      done_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    Q_IDLE  = 6'b000001,
    Q_SEND  = 6'b000010,
    Q_HDR   = 6'b000100,
    Q_RDATA = 6'b001000,
    Q_TAIL  = 6'b010000,
    Q_DONE  = 6'b100000
  } req_state_t;

  typedef struct packed {
    req_state_t  st;
    logic [3:0]  idx;
    logic [2:0]  cnt;
    logic        wr;
    logic [23:0] rid;
    logic [15:0] regn;
    logic [31:0] wdata;
    logic [31:0] dest;
    logic [31:0] rdata;
    logic        ok;
  } req_regs_t;

  localparam logic [3:0] IDX_REG_LO = 4'h5;
  localparam logic [3:0] IDX_LAST   = 4'hA;

  req_regs_t s_q;
  req_regs_t s_d;

  assign ps_res_id  = ps_resource_id(cmd_reg);
  assign done_ok    = s_q.ok;
  assign done_rdata = s_q.rdata;
  assign link.req_dest = s_q.dest;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    cmd_ready      = 1'b0;
    done           = 1'b0;
    link.req_valid = 1'b0;
    link.req_ctrl  = 1'b0;
    link.req_data  = 8'h00;
    link.rsp_ready = 1'b0;
    case (s_q.st)
      Q_IDLE: begin
        cmd_ready = 1'b1;
        if (cmd_valid) begin
          s_d.wr    = cmd_write;
          s_d.rid   = cmd_reply_id;
          s_d.regn  = cmd_reg;
          s_d.wdata = cmd_wdata;
          s_d.dest  = {cmd_target_id, cmd_node ? NODE_EP_LO : TILE_EP_LO};
          s_d.idx   = '0;
          s_d.ok    = 1'b0;
          s_d.st    = Q_SEND;
        end
      end
      Q_SEND: begin
        link.req_valid = 1'b1;
        case (s_q.idx)
          4'h0: begin
            link.req_ctrl = 1'b1;
            link.req_data = s_q.wr ? TOK_WRITE : TOK_READ;
          end
          4'h1: link.req_data = s_q.rid[23:16];
          4'h2: link.req_data = s_q.rid[15:8];
          4'h3: link.req_data = s_q.rid[7:0];
          4'h4: link.req_data = s_q.regn[15:8];
          4'h5: link.req_data = s_q.regn[7:0];
          4'h6: link.req_data = s_q.wdata[31:24];
          4'h7: link.req_data = s_q.wdata[23:16];
          4'h8: link.req_data = s_q.wdata[15:8];
          4'h9: link.req_data = s_q.wdata[7:0];
          default: begin
            link.req_ctrl = 1'b1;
            link.req_data = TOK_END;
          end
        endcase
        if (link.req_ready) begin
          if (s_q.idx == IDX_REG_LO && !s_q.wr) begin
            s_d.idx = IDX_LAST;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
          end
          if (s_q.idx == IDX_LAST) begin
            if (s_q.wr && s_q.rid[7:0] == RID_NO_REPLY) begin
              s_d.ok = 1'b1;
              s_d.st = Q_DONE;
            end else begin
              s_d.st = Q_HDR;
            end
          end
        end
      end
      Q_HDR: begin
        link.rsp_ready = 1'b1;
        if (link.rsp_valid && link.rsp_ctrl) begin
          s_d.ok  = (link.rsp_data == TOK_ACK);
          s_d.cnt = '0;
          s_d.st  = (link.rsp_data == TOK_ACK && !s_q.wr) ? Q_RDATA : Q_TAIL;
        end
      end
      Q_RDATA: begin
        link.rsp_ready = 1'b1;
        if (link.rsp_valid && !link.rsp_ctrl) begin
          s_d.rdata = {s_q.rdata[23:0], link.rsp_data};
          s_d.cnt   = s_q.cnt + 3'h1;
          if (s_q.cnt == DATA_LAST) s_d.st = Q_TAIL;
        end
      end
      Q_TAIL: begin
        link.rsp_ready = 1'b1;
        if (link.rsp_valid && link.rsp_ctrl && link.rsp_data == TOK_END) s_d.st = Q_DONE;
      end
      Q_DONE: begin
        done   = 1'b1;
        s_d.st = Q_IDLE;
      end
      default: s_d.st = Q_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q    <= '0;
      s_q.st <= Q_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : cfg_requester

// file: cfg_agent.sv
// Configuration agent: decodes token messages and answers those addressed to it, except reply-free writes
`timescale 1ns/1ps
module cfg_agent
  import cfg_msg_pkg::*;
#(
  parameter logic        IS_NODE = 1'b0,
  parameter logic [15:0] OWN_ID  = 16'h0000
)(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  cfg_link_if.agent        link,
  output logic             cfg_valid,
  output logic             cfg_write,
  output logic [15:0]      cfg_addr,
  output logic [31:0]      cfg_wdata,
  input  wire logic        cfg_ok,
  input  wire logic [31:0] cfg_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    A_IDLE  = 9'b000000001,
    A_RID   = 9'b000000010,
    A_REG   = 9'b000000100,
    A_DATA  = 9'b000001000,
    A_END   = 9'b000010000,
    A_ACT   = 9'b000100000,
    A_HDR   = 9'b001000000,
    A_RDATA = 9'b010000000,
    A_TAIL  = 9'b100000000
  } agent_state_t;

  typedef struct packed {
    agent_state_t st;
    logic [2:0]   cnt;
    logic         wr;
    logic         dest_ok;
    logic [23:0]  rid;
    logic [15:0]  regn;
    logic [31:0]  data;
    logic         ok;
  } agent_regs_t;

  agent_regs_t s_q;
  agent_regs_t s_d;

  logic [31:0] own_ep;
  logic        tok_ctrl;
  logic        tok_data;

  // Endpoint this agent answers to
  assign own_ep = {OWN_ID, IS_NODE ? NODE_EP_LO : TILE_EP_LO};

  assign tok_ctrl = link.req_valid && link.req_ready && link.req_ctrl;
  assign tok_data = link.req_valid && link.req_ready && !link.req_ctrl;

  // ----------------------------------------------------------------
  // Outputs held in flops
  // ----------------------------------------------------------------
  assign cfg_write     = s_q.wr;
  assign cfg_addr      = s_q.regn;
  assign cfg_wdata     = s_q.data;
  assign link.rsp_dest = s_q.rid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    cfg_valid      = 1'b0;
    link.req_ready = 1'b0;
    link.rsp_valid = 1'b0;
    link.rsp_ctrl  = 1'b0;
    link.rsp_data  = 8'h00;
    case (s_q.st)

      // Wait for an opening token; stray data is swallowed
      A_IDLE: begin
        link.req_ready = 1'b1;
        if (tok_ctrl && (link.req_data == TOK_WRITE || link.req_data == TOK_READ)) begin
          s_d.wr      = (link.req_data == TOK_WRITE);
          s_d.dest_ok = (link.req_dest == own_ep);
          s_d.cnt     = '0;
          s_d.st      = A_RID;
        end
      end

      // Reply identifier, three bytes
      A_RID: begin
        link.req_ready = 1'b1;
        if (tok_ctrl) begin
          s_d.st = A_IDLE;
        end else if (tok_data) begin
          s_d.rid = {s_q.rid[15:0], link.req_data};
          s_d.cnt = s_q.cnt + 3'h1;
          if (s_q.cnt == RID_LAST) begin
            s_d.cnt = '0;
            s_d.st  = A_REG;
          end
        end
      end

      // Register number, two bytes
      A_REG: begin
        link.req_ready = 1'b1;
        if (tok_ctrl) begin
          s_d.st = A_IDLE;
        end else if (tok_data) begin
          s_d.regn = {s_q.regn[7:0], link.req_data};
          s_d.cnt  = s_q.cnt + 3'h1;
          if (s_q.cnt == REG_LAST) begin
            s_d.cnt = '0;
            s_d.st  = s_q.wr ? A_DATA : A_END;
          end
        end
      end

      // Write data, four bytes
      A_DATA: begin
        link.req_ready = 1'b1;
        if (tok_ctrl) begin
          s_d.st = A_IDLE;
        end else if (tok_data) begin
          s_d.data = {s_q.data[23:0], link.req_data};
          s_d.cnt  = s_q.cnt + 3'h1;
          if (s_q.cnt == DATA_LAST) s_d.st = A_END;
        end
      end

      // Closing token; malformed or misdirected messages are dropped
      A_END: begin
        link.req_ready = 1'b1;
        if (tok_ctrl && link.req_data == TOK_END && s_q.dest_ok) begin
          s_d.st = A_ACT;
        end else if (tok_ctrl || tok_data) begin
          s_d.st = A_IDLE;
        end
      end

      // One-cycle access to the configuration logic
      A_ACT: begin
        cfg_valid = 1'b1;
        s_d.ok    = cfg_ok;
        if (!s_q.wr) s_d.data = cfg_rdata;
        s_d.cnt = '0;
        if (s_q.wr && s_q.rid[7:0] == RID_NO_REPLY) begin
          s_d.st = A_IDLE;
        end else begin
          s_d.st = A_HDR;
        end
      end

      // Status token of the reply
      A_HDR: begin
        link.rsp_valid = 1'b1;
        link.rsp_ctrl  = 1'b1;
        link.rsp_data  = s_q.ok ? TOK_ACK : TOK_NACK;
        if (link.rsp_ready) begin
          s_d.st = (s_q.ok && !s_q.wr) ? A_RDATA : A_TAIL;
        end
      end

      // Read data, most significant byte first
      A_RDATA: begin
        link.rsp_valid = 1'b1;
        link.rsp_data  = s_q.data[31:24];
        if (link.rsp_ready) begin
          s_d.data = {s_q.data[23:0], 8'h00};
          s_d.cnt  = s_q.cnt + 3'h1;
          if (s_q.cnt == DATA_LAST) s_d.st = A_TAIL;
        end
      end

      // Closing token of the reply
      A_TAIL: begin
        link.rsp_valid = 1'b1;
        link.rsp_ctrl  = 1'b1;
        link.rsp_data  = TOK_END;
        if (link.rsp_ready) s_d.st = A_IDLE;
      end

      default: s_d.st = A_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q    <= '0;
      s_q.st <= A_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : cfg_agent

// file: cfg_link_monitor.sv
// Concurrent checks on the configuration token link
`timescale 1ns/1ps
module cfg_link_monitor
  import cfg_msg_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire logic        req_ctrl,
  input wire logic [7:0]  req_data,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_ctrl,
  input wire logic [7:0]  rsp_data,
  input wire logic [23:0] rsp_dest,
  input wire logic        rsp_ready
);
  logic req_end;
  logic req_tk;
  logic rsp_tk;
  logic read_q;

  assign req_tk  = req_valid && req_ready && req_ctrl;
  assign req_end = req_tk && req_data == TOK_END;
  assign rsp_tk  = rsp_valid && rsp_ready && rsp_ctrl;

  // Remembers whether the open message is a read
  always_ff @(posedge sys_clk) begin
    if (reset) read_q <= 1'b0;
    else if (req_tk && req_data == TOK_READ) read_q <= 1'b1;
    else if (req_tk && req_data == TOK_WRITE) read_q <= 1'b0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_REQ_OPEN: assert property (
    $rose(req_valid) |-> req_ctrl && (req_data == TOK_WRITE || req_data == TOK_READ))
    else $error("Message opened without a request token");
  AST_REPLY_TIME: assert property (
    req_end |-> ##2 (rsp_valid == (read_q || rsp_dest[7:0] != RID_NO_REPLY)))
    else $error("Reply presence or timing wrong after closing token");
  AST_EARLY_RSP: assert property (
    $rose(rsp_valid) |-> $past(req_end, 2))
    else $error("Reply started without a closed request");
  AST_REPLY_OPEN: assert property (
    $rose(rsp_valid) |-> rsp_ctrl && (rsp_data == TOK_ACK || rsp_data == TOK_NACK))
    else $error("Reply opened with a wrong token");
  AST_NACK_CLOSE: assert property (
    rsp_tk && rsp_data == TOK_NACK |=> rsp_valid && rsp_ctrl && rsp_data == TOK_END)
    else $error("Failure reply not closed at once");
  AST_WRITE_CLOSE: assert property (
    rsp_tk && rsp_data == TOK_ACK && !read_q |=> rsp_valid && rsp_ctrl && rsp_data == TOK_END)
    else $error("Write success reply not closed at once");
  AST_READ_DATA: assert property (
    rsp_tk && rsp_data == TOK_ACK && read_q |=> (rsp_valid && !rsp_ctrl) [*4]
    ##1 (rsp_valid && rsp_ctrl && rsp_data == TOK_END))
    else $error("Read reply lacks four data bytes and close");
  AST_BUSY_REFUSE: assert property (
    rsp_valid |-> !req_ready)
    else $error("Request accepted while replying");

  cover property (rsp_tk && rsp_data == TOK_NACK);
  cover property (rsp_tk && rsp_data == TOK_ACK && read_q);
  cover property (req_end ##2 !rsp_valid);
endmodule : cfg_link_monitor

// file: config_register_message_access_bench.sv
// Self-checking bench joining requester and agent
`timescale 1ns/1ps
module config_register_message_access_bench
  import cfg_msg_pkg::*;
;
  localparam logic [15:0] TILE_ID = 16'h0042;
  logic        sys_clk;
  logic        reset;
  logic        cmd_valid;
  logic        cmd_write;
  logic        cmd_node;
  logic [15:0] cmd_target_id;
  logic [23:0] cmd_reply_id;
  logic [15:0] cmd_reg;
  logic [31:0] cmd_wdata;
  logic        cmd_ready;
  logic [31:0] ps_res_id;
  logic        done;
  logic        done_ok;
  logic [31:0] done_rdata;
  logic        cfg_valid;
  logic        cfg_write;
  logic [15:0] cfg_addr;
  logic [31:0] cfg_wdata;
  logic        cfg_ok;
  logic [31:0] cfg_rdata;
  logic [48:0] exp_tok[$];
  logic [48:0] exp_rsp[$];
  logic [48:0] exp_cfg[$];
  logic [48:0] exp_done[$];
  logic [48:0] exp_dest[$];
  int          failures = 0;
  int          num_checks = 0;

  cfg_link_if lk ();
  cfg_requester cfg_requester_i (.sys_clk(sys_clk), .reset(reset), .link(lk),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_node(cmd_node),
    .cmd_target_id(cmd_target_id), .cmd_reply_id(cmd_reply_id), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .ps_res_id(ps_res_id), .done(done),
    .done_ok(done_ok), .done_rdata(done_rdata));
  cfg_agent #(.IS_NODE(1'b0), .OWN_ID(TILE_ID)) cfg_agent_i (.sys_clk(sys_clk),
    .reset(reset), .link(lk), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ok(cfg_ok), .cfg_rdata(cfg_rdata));
  cfg_link_monitor cfg_link_monitor_i (.sys_clk(sys_clk), .reset(reset),
    .req_valid(lk.req_valid), .req_ctrl(lk.req_ctrl), .req_data(lk.req_data),
    .req_ready(lk.req_ready), .rsp_valid(lk.rsp_valid), .rsp_ctrl(lk.rsp_ctrl),
    .rsp_data(lk.rsp_data), .rsp_dest(lk.rsp_dest), .rsp_ready(lk.rsp_ready));

  // Config logic: only registers with a zero upper byte exist
  assign cfg_ok    = cfg_addr[15:8] == 8'h00;
  assign cfg_rdata = {cfg_addr, ~cfg_addr};

  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [48:0] seen, input logic [48:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [48:0] take(ref logic [48:0] q[$]);
    take = q.size() > 0 ? q.pop_front() : 'x;
  endfunction : take

  task automatic conclude();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // Called at a falling edge; leaves cmd_valid high for back-to-back use
  // Node addressing is only used with reply-free writes: the tile agent drops them
  task automatic run(input logic wr, input logic [23:0] rid, input logic [15:0] rg,
                     input logic [31:0] wd, input logic nd);
    logic        ok;
    logic        quiet;
    logic [31:0] rd;
    ok = rg[15:8] == 8'h00;
    quiet = wr && rid[7:0] == RID_NO_REPLY;
    rd = {rg, ~rg};
    exp_tok.push_back(49'({1'b1, wr ? TOK_WRITE : TOK_READ}));
    exp_dest.push_back(49'({TILE_ID, nd ? NODE_EP_LO : TILE_EP_LO}));
    for (int i = 2; i >= 0; i--) exp_tok.push_back(49'({1'b0, rid[i*8 +: 8]}));
    for (int i = 1; i >= 0; i--) exp_tok.push_back(49'({1'b0, rg[i*8 +: 8]}));
    if (wr) for (int i = 3; i >= 0; i--) exp_tok.push_back(49'({1'b0, wd[i*8 +: 8]}));
    exp_tok.push_back(49'({1'b1, TOK_END}));
    if (!nd) exp_cfg.push_back({wr, rg, wr ? wd : 32'h0});
    if (!quiet) begin
      exp_rsp.push_back(49'({rid, 1'b1, ok ? TOK_ACK : TOK_NACK}));
      if (ok && !wr) begin
        for (int i = 3; i >= 0; i--) exp_rsp.push_back(49'({rid, 1'b0, rd[i*8 +: 8]}));
      end
      exp_rsp.push_back(49'({rid, 1'b1, TOK_END}));
    end
    exp_done.push_back(49'({wr, quiet || ok, (wr || !ok) ? 32'h0 : rd}));
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_node = nd;
    cmd_reply_id = rid;
    cmd_reg = rg;
    cmd_wdata = wd;
    #1 check(49'(ps_res_id), 49'({8'h00, rg, PS_CODE}));
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : run

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset === 1'b0) begin
      if (lk.req_valid === 1'b1 && lk.req_ready === 1'b1) begin
        check(49'({lk.req_ctrl, lk.req_data}), take(exp_tok));
        if (lk.req_ctrl && lk.req_data[7:1] == 7'h60)
          check(49'(lk.req_dest), take(exp_dest));
      end
      if (lk.rsp_valid === 1'b1 && lk.rsp_ready === 1'b1)
        check(49'({lk.rsp_dest, lk.rsp_ctrl, lk.rsp_data}), take(exp_rsp));
      if (cfg_valid === 1'b1)
        check({cfg_write, cfg_addr, cfg_write ? cfg_wdata : 32'h0}, take(exp_cfg));
      if (done === 1'b1) begin : done_chk
        logic [48:0] e;
        e = take(exp_done);
        check(49'({e[33], done_ok, (e[33] || !e[32]) ? 32'h0 : done_rdata}), e);
      end
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    sys_clk = 1'b0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_node = 1'b0;
    cmd_target_id = TILE_ID;
    cmd_reply_id = 24'h0;
    cmd_reg = 16'h0;
    cmd_wdata = 32'h0;
    r = $urandom(32'hB696);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    run(1'b1, 24'h1234FF, 16'h0100, 32'hDEADBEEF, 1'b0);
    run(1'b0, 24'h123456, 16'h0100, 32'h0, 1'b0);
    run(1'b1, 24'h123457, 16'h0200, 32'h01234567, 1'b0);
    run(1'b0, 24'hABCDEF, 16'h00A5, 32'h0, 1'b0);
    run(1'b1, 24'h0000FE, 16'h0003, 32'h89ABCDEF, 1'b0);
    run(1'b1, 24'h5678FF, 16'h0001, 32'hCAFEF00D, 1'b1);
    repeat (24) begin
      r = $urandom;
      run(r[0], {r[31:16], (r[0] && r[1]) ? 8'hFF : (r[15:8] & 8'hFE)},
          {7'h00, r[2], r[23:16]}, $urandom, r[0] && r[1] && r[3]);
    end
    cmd_valid = 1'b0;
    for (int i = 0; i < 200 && exp_done.size() > 0; i++) @(negedge sys_clk);
    check(49'(exp_tok.size() + exp_rsp.size() + exp_cfg.size() + exp_done.size()
              + exp_dest.size()), 49'h0);
    conclude();
  end

  initial begin
    #20000;
    failures++;
    conclude();
  end
endmodule : config_register_message_access_bench
